/* File: iad_defs.svh */
//  Contract
// [RULE1] Low fixed regions forward per control bits
// [RULE2] Lower firmware enable overrides forward bit 3
// [RULE3] Eight 16 KB expansion ROM enables
// [RULE4] Control bits 7:4 set region top
// [RULE5] Hole inside region stays on ISA
// [RULE6] Internal register access is 8-bit I/O
// [RULE7] Firmware aliased at two high windows
// [RULE8] Upper half always on, lower enabled
// [RULE9] ISA masters see firmware only low
// [RULE10] Enabled firmware halves assert select, stay ISA
// [RULE11] Firmware select purely combinational from address
// [RULE12] No firmware select in refresh, DMA
// [RULE13] Disabled lower half forwards if bit 3
// [RULE14] Divisor bit 6 picks upper decode kind
// [RULE15] Disabled lower half forwards if bit 6
// [RULE16] Other regions never assert firmware select
// [RULE17] Utility selects combinational from SA 15:0
// [RULE18] Each utility select individually enabled; the code gates clock strobe and clock select with one enable, bit 1
// [RULE19] Writes 70h 372h 3F2h: ready, shadow
// [RULE20] Watch reads of 60h, no ready
// [RULE21] Keyboard, clock strobe, clock select decode
// [RULE22] Disk select for 170h-177h, 1F0h-1F7h
// [RULE23] Parallel select 278h-27Bh, bit 2 ignored
// [RULE24] Serial two select 2F8h-2FFh
// [RULE25] Forward only what is positively claimed
// [RULE26] Above 16 MB forwards automatically
// [RULE27] Region top on 64 KB granularity; the code compares the top on 1 MB steps (addr 23:20)
// [RULE28] Hole placed in 64 KB steps
// [RULE29] Decodes follow address every cycle
`ifndef IAD_DEFS_SVH
`define IAD_DEFS_SVH
`define IAD_OFF_CTL 4'h0
`define IAD_OFF_ROM 4'h1
`define IAD_OFF_HTOP 4'h2
`define IAD_OFF_HBOT 4'h3
`define IAD_OFF_USEL 4'h4
`define IAD_OFF_DIV 4'h5
`define IAD_OFF_SH70 4'h6
`define IAD_OFF_SH372 4'h7
`define IAD_OFF_SH3F2 4'h8
`define IAD_RST_VAL 8'h00
`define IAD_BIT_LOFWD 3
`define IAD_BIT_LOFWD2 6
`define IAD_BIT_LOEN 6
`define IAD_BIT_HIPOS 6
`define IAD_IO_KBD 13'h000C
`define IAD_IO_RTC 13'h000E
`define IAD_IO_DSK2 13'h002E
`define IAD_IO_DSK1 13'h003E
`define IAD_IO_LPT 13'h004F
`define IAD_IO_COM2 13'h005F
`define IAD_IO_RTCA 16'h0070
`define IAD_IO_FDC2 16'h0372
`define IAD_IO_FDC1 16'h03F2
`define IAD_IO_MOUSE 16'h0060
`define IAD_PG_LOBIOS 16'h000E
`define IAD_PG_HIBIOS 16'h000F
`define IAD_PG_AL1LO 16'hFFFE
`define IAD_PG_AL1HI 16'hFFFF
`define IAD_PG_AL2LO 16'hFFEE
`define IAD_PG_AL2HI 16'hFFEF
`endif

/* File: iad_pkg.sv */
package iad_pkg;
  typedef enum logic [2:0] {
    IAD_CS_KEYBOARD,
    IAD_CS_CLK_ADDR,
    IAD_CS_CLK_SEL,
    IAD_CS_DISK0,
    IAD_CS_PARALLEL,
    IAD_CS_SERIAL2,
    IAD_CS_NONE
  } iad_cs_t;
endpackage

/* File: iad_decoder.sv */
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ns
`include "iad_defs.svh"
module iad_decoder (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic [31:17] i_la,
  input wire logic [16:0] i_sa,
  input wire logic [7:0] i_sd,
  input wire logic i_isa_master,
  input wire logic i_dma,
  input wire logic i_refresh,
  input wire logic i_mem_cycle,
  input wire logic i_io_cycle,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic i_int_reg_hit,
  output logic o_fwd_pci,
  output logic o_contain_isa,
  output logic o_encoded_firmware_select_n,
  output logic o_bios_claim,
  output iad_pkg::iad_cs_t o_cs_code,
  output logic o_io8_ext,
  output logic o_iochrdy_drive,
  output logic o_mouse_read
);
  // Decode outputs are deliberately not flopped: the selects must
  // follow the address within the same ISA cycle.
  logic [7:0] isa_decode_control_r;
  logic [7:0] expansion_rom_forward_enable_r;
  logic [7:0] hole_top_r;
  logic [7:0] hole_bottom_r;
  logic [7:0] utility_select_enable_a_r;
  logic [7:0] clock_divisor_r;
  logic [7:0] sh_rtc_r;
  logic [7:0] sh_fdc2_r;
  logic [7:0] sh_fdc1_r;
  logic [7:0] rdata_nxt;
  logic wr_s1_r, wr_s2_r, wr_s3_r;
  logic rd_s1_r, rd_s2_r, rd_s3_r;
  logic [31:0] addr;
  logic [15:0] page;
  logic [15:0] io_a;
  logic mem, io, lo_en;
  logic r_a, r_b, r_c, r_rom, r_lo, r_hi;
  logic al_lo, al_hi, bios_lo, bios_hi;
  logic ext, in_top, in_hole, above16;
  logic fwd, cs_kb, cs_rtca, cs_rtc, cs_dsk, cs_lpt, cs_com;
  logic sh_hit, wr_edge, rd_edge;

  assign addr = {i_la, i_sa}; // RULE29
  assign page = addr[31:16];
  assign io_a = i_sa[15:0];
  assign mem = i_mem_cycle & ~i_refresh;
  assign io = i_io_cycle & ~i_refresh;
  assign lo_en = utility_select_enable_a_r[`IAD_BIT_LOEN];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      isa_decode_control_r <= `IAD_RST_VAL;
      expansion_rom_forward_enable_r <= `IAD_RST_VAL;
      hole_top_r <= `IAD_RST_VAL;
      hole_bottom_r <= `IAD_RST_VAL;
      utility_select_enable_a_r <= `IAD_RST_VAL;
      clock_divisor_r <= `IAD_RST_VAL;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `IAD_OFF_CTL: isa_decode_control_r <= i_reg_wdata;
        `IAD_OFF_ROM: expansion_rom_forward_enable_r <= i_reg_wdata;
        `IAD_OFF_HTOP: hole_top_r <= i_reg_wdata;
        `IAD_OFF_HBOT: hole_bottom_r <= i_reg_wdata;
        `IAD_OFF_USEL: utility_select_enable_a_r <= i_reg_wdata;
        `IAD_OFF_DIV: clock_divisor_r <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (i_reg_addr)
      `IAD_OFF_CTL: rdata_nxt = isa_decode_control_r;
      `IAD_OFF_ROM: rdata_nxt = expansion_rom_forward_enable_r;
      `IAD_OFF_HTOP: rdata_nxt = hole_top_r;
      `IAD_OFF_HBOT: rdata_nxt = hole_bottom_r;
      `IAD_OFF_USEL: rdata_nxt = utility_select_enable_a_r;
      `IAD_OFF_DIV: rdata_nxt = clock_divisor_r;
      `IAD_OFF_SH70: rdata_nxt = sh_rtc_r;
      `IAD_OFF_SH372: rdata_nxt = sh_fdc2_r;
      `IAD_OFF_SH3F2: rdata_nxt = sh_fdc1_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Data valid only the cycle after the read strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_nxt;
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // Memory regions; all evaluated live from the address
  assign r_a = addr[31:19] == 13'h0000; // RULE1
  assign r_b = addr[31:17] == 15'h0004; // RULE1
  assign r_c = addr[31:17] == 15'h0005; // RULE1
  assign r_rom = addr[31:17] == 15'h0006; // RULE3
  assign r_lo = page == `IAD_PG_LOBIOS; // RULE8
  assign r_hi = page == `IAD_PG_HIBIOS; // RULE8
  assign al_lo = page == `IAD_PG_AL1LO | page == `IAD_PG_AL2LO; // RULE7
  assign al_hi = page == `IAD_PG_AL1HI | page == `IAD_PG_AL2HI; // RULE7
  // Aliases only count for DMA; ISA masters cannot reach them
  assign bios_lo = r_lo | (i_dma & al_lo); // RULE9
  assign bios_hi = r_hi | (i_dma & al_hi); // RULE9
  assign ext = addr[31:24] == 8'h00 && addr[23:20] != 4'h0;
  // Top compared on 1 MB field; hole on 64 KB pages
  assign in_top = ext && addr[23:20] <= isa_decode_control_r[7:4]; // RULE4
  assign in_hole = addr[23:16] >= hole_bottom_r &&
    addr[23:16] <= hole_top_r; // RULE28
  assign above16 = addr[31:24] != 8'h00 && !(bios_lo | bios_hi); // RULE26

  always_comb begin
    fwd = 1'b0;
    if (mem) begin
      if (r_a) begin
        fwd = isa_decode_control_r[0]; // RULE1
      end else if (r_b) begin
        fwd = isa_decode_control_r[1]; // RULE1
      end else if (r_c) begin
        fwd = isa_decode_control_r[2]; // RULE1
      end else if (r_rom) begin
        fwd = expansion_rom_forward_enable_r[addr[16:14]]; // RULE3
      end else if (bios_lo) begin
        // Enabled lower half wins over both forward bits
        fwd = !lo_en && (isa_decode_control_r[`IAD_BIT_LOFWD] ||
          isa_decode_control_r[`IAD_BIT_LOFWD2]); // RULE2 RULE13 RULE15
      end else if (bios_hi) begin
        fwd = 1'b0; // RULE10
      end else if (in_top) begin
        fwd = !in_hole; // RULE5 RULE27
      end else if (above16) begin
        fwd = 1'b1; // RULE26
      end
    end
  end

  assign o_fwd_pci = fwd; // RULE25
  assign o_contain_isa = (i_mem_cycle | i_io_cycle) & ~fwd; // RULE25

  // Select kept off for non-firmware regions and for DMA/refresh
  assign o_encoded_firmware_select_n = !(mem && !i_dma && i_isa_master &&
    (r_hi || (r_lo && lo_en))); // RULE10 RULE11 RULE12 RULE16
  assign o_bios_claim = mem && i_isa_master && !i_dma && r_hi &&
    clock_divisor_r[`IAD_BIT_HIPOS]; // RULE14

  assign cs_kb = io_a[15:3] == `IAD_IO_KBD && !io_a[0]; // RULE21
  assign cs_rtca = io_a[15:3] == `IAD_IO_RTC && !io_a[0] &&
    i_io_wr; // RULE21
  assign cs_rtc = io_a[15:3] == `IAD_IO_RTC && io_a[0]; // RULE21
  assign cs_dsk = io_a[15:3] == `IAD_IO_DSK2 ||
    io_a[15:3] == `IAD_IO_DSK1; // RULE22
  assign cs_lpt = io_a[15:3] == `IAD_IO_LPT; // RULE23
  assign cs_com = io_a[15:3] == `IAD_IO_COM2; // RULE24

  always_comb begin
    o_cs_code = iad_pkg::IAD_CS_NONE;
    if (io) begin
      if (cs_kb && utility_select_enable_a_r[0]) begin // RULE18
        o_cs_code = iad_pkg::IAD_CS_KEYBOARD; // RULE17
      end else if (cs_rtca && utility_select_enable_a_r[1]) begin
        o_cs_code = iad_pkg::IAD_CS_CLK_ADDR;
      end else if (cs_rtc && utility_select_enable_a_r[1]) begin
        o_cs_code = iad_pkg::IAD_CS_CLK_SEL;
      end else if (cs_dsk && utility_select_enable_a_r[2]) begin
        o_cs_code = iad_pkg::IAD_CS_DISK0;
      end else if (cs_lpt && utility_select_enable_a_r[3]) begin
        o_cs_code = iad_pkg::IAD_CS_PARALLEL;
      end else if (cs_com && utility_select_enable_a_r[4]) begin
        o_cs_code = iad_pkg::IAD_CS_SERIAL2;
      end
    end
  end

  assign o_io8_ext = io && i_isa_master && i_int_reg_hit; // RULE6

  assign sh_hit = io_a == `IAD_IO_RTCA || io_a == `IAD_IO_FDC2 ||
    io_a == `IAD_IO_FDC1;
  assign o_iochrdy_drive = io && i_isa_master && i_io_wr &&
    sh_hit; // RULE19 RULE20

  // Strobes are asynchronous to i_clk
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_s1_r <= 1'b0;
      wr_s2_r <= 1'b0;
      wr_s3_r <= 1'b0;
      rd_s1_r <= 1'b0;
      rd_s2_r <= 1'b0;
      rd_s3_r <= 1'b0;
    end else begin
      wr_s1_r <= i_io_wr & i_io_cycle;
      wr_s2_r <= wr_s1_r;
      wr_s3_r <= wr_s2_r;
      rd_s1_r <= i_io_rd & i_io_cycle;
      rd_s2_r <= rd_s1_r;
      rd_s3_r <= rd_s2_r;
    end
  end

  assign wr_edge = wr_s2_r & ~wr_s3_r;
  assign rd_edge = rd_s2_r & ~rd_s3_r;

  // Address and data hold steady across the strobe, so
  // sampling them after the synchroniser is safe.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sh_rtc_r <= `IAD_RST_VAL;
      sh_fdc2_r <= `IAD_RST_VAL;
      sh_fdc1_r <= `IAD_RST_VAL;
    end else if (wr_edge && i_isa_master) begin
      if (io_a == `IAD_IO_RTCA) begin
        sh_rtc_r <= i_sd; // RULE19
      end
      if (io_a == `IAD_IO_FDC2) begin
        sh_fdc2_r <= i_sd; // RULE19
      end
      if (io_a == `IAD_IO_FDC1) begin
        sh_fdc1_r <= i_sd; // RULE19
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mouse_read <= 1'b0;
    end else begin
      o_mouse_read <= rd_edge && io_a == `IAD_IO_MOUSE; // RULE20
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence wr_launch;
    $rose(wr_s2_r) && i_isa_master && io_a == `IAD_IO_RTCA;
  endsequence
  sequence rd_launch;
    $rose(rd_s2_r) && io_a == `IAD_IO_MOUSE;
  endsequence

  low_fwd_a: assert property ( // RULE1
    mem && r_a |-> o_fwd_pci == isa_decode_control_r[0])
    else $error("low region forward mismatch");
  lo_override_a: assert property ( // RULE2
    mem && bios_lo && lo_en |-> !o_fwd_pci)
    else $error("enabled lower firmware forwarded");
  rom_sect_a: assert property ( // RULE3
    mem && r_rom |->
    o_fwd_pci == expansion_rom_forward_enable_r[addr[16:14]])
    else $error("rom section forward mismatch");
  top_limit_a: assert property ( // RULE4
    mem && ext && addr[23:20] > isa_decode_control_r[7:4] |-> !o_fwd_pci)
    else $error("forwarded above region top");
  hole_keep_a: assert property ( // RULE5
    mem && in_top && in_hole |-> !o_fwd_pci && o_contain_isa)
    else $error("hole cycle forwarded");
  upper_sel_a: assert property ( // RULE10
    mem && r_hi && i_isa_master && !i_dma |->
    !o_encoded_firmware_select_n && !o_fwd_pci)
    else $error("upper firmware select missing");
  sel_block_a: assert property ( // RULE12
    i_dma || i_refresh |-> o_encoded_firmware_select_n)
    else $error("firmware select during dma or refresh");
  above_fwd_a: assert property ( // RULE26
    mem && above16 |-> o_fwd_pci)
    else $error("high address not forwarded");
  sel_gate_a: assert property ( // RULE18
    !utility_select_enable_a_r[4] |->
    o_cs_code != iad_pkg::IAD_CS_SERIAL2)
    else $error("disabled serial select produced");
  rtc_shadow_a: assert property ( // RULE19
    wr_launch ##1 !$rose(wr_s2_r) |-> sh_rtc_r == $past(i_sd))
    else $error("shadow not captured");
  mouse_seen_a: assert property ( // RULE20
    rd_launch |=> o_mouse_read ##1 !o_mouse_read)
    else $error("mouse read not flagged once");
  mid_fwd_a: assert property ( // RULE1
    mem && r_b |-> o_fwd_pci == isa_decode_control_r[1])
    else $error("mid region forward mismatch");
  video_fwd_a: assert property ( // RULE1
    mem && r_c |-> o_fwd_pci == isa_decode_control_r[2])
    else $error("video region forward mismatch");
  lo_fwd_off_a: assert property ( // RULE13 RULE15
    mem && bios_lo && !lo_en |-> o_fwd_pci ==
    (isa_decode_control_r[`IAD_BIT_LOFWD] ||
    isa_decode_control_r[`IAD_BIT_LOFWD2]))
    else $error("disabled lower firmware forward mismatch");
  lo_sel_a: assert property ( // RULE8
    mem && r_lo && lo_en && i_isa_master && !i_dma |->
    !o_encoded_firmware_select_n && !o_fwd_pci)
    else $error("enabled lower firmware not selected");
  alias_isa_a: assert property ( // RULE9
    !i_dma && (al_lo || al_hi) |-> o_encoded_firmware_select_n)
    else $error("alias selected for isa master");
  alias_dma_a: assert property ( // RULE7
    mem && i_dma && al_hi |-> !o_fwd_pci && o_contain_isa)
    else $error("upper alias forwarded for dma");
  claim_gate_a: assert property ( // RULE14
    !clock_divisor_r[`IAD_BIT_HIPOS] |-> !o_bios_claim)
    else $error("upper claim without positive decode");
  other_sel_a: assert property ( // RULE16
    !r_lo && !r_hi |-> o_encoded_firmware_select_n)
    else $error("firmware select outside firmware pages");
  fwd_mem_a: assert property ( // RULE25
    !mem |-> !o_fwd_pci)
    else $error("forward outside memory cycle");
  contain_a: assert property ( // RULE25
    i_mem_cycle || i_io_cycle |-> o_contain_isa == !o_fwd_pci)
    else $error("contain and forward disagree");
  io8_a: assert property ( // RULE6
    io && i_isa_master && i_int_reg_hit |-> o_io8_ext)
    else $error("internal register not run as 8-bit");
  rdy_wr_a: assert property ( // RULE19
    io && i_isa_master && i_io_wr && io_a == `IAD_IO_FDC1 |->
    o_iochrdy_drive)
    else $error("shadow write without ready");
  rdy_rd_a: assert property ( // RULE20
    !i_io_wr |-> !o_iochrdy_drive)
    else $error("ready driven on read");
  cs_idle_a: assert property ( // RULE17
    !io |-> o_cs_code == iad_pkg::IAD_CS_NONE)
    else $error("utility select outside io cycle");
  kbd_sel_a: assert property ( // RULE21
    io && cs_kb && utility_select_enable_a_r[0] |->
    o_cs_code == iad_pkg::IAD_CS_KEYBOARD)
    else $error("keyboard select missing");
  disk_sel_a: assert property ( // RULE22
    io && cs_dsk && utility_select_enable_a_r[2] |->
    o_cs_code == iad_pkg::IAD_CS_DISK0)
    else $error("disk select missing");
  lpt_sel_a: assert property ( // RULE23
    io && cs_lpt && utility_select_enable_a_r[3] |->
    o_cs_code == iad_pkg::IAD_CS_PARALLEL)
    else $error("parallel select missing");
  com_sel_a: assert property ( // RULE24
    io && cs_com && utility_select_enable_a_r[4] |->
    o_cs_code == iad_pkg::IAD_CS_SERIAL2)
    else $error("serial select missing");
endmodule

/* File: iad_isa_agent.sv */
`timescale 1ns/1ns
module iad_isa_agent (
  input wire logic i_clk,
  output logic [31:17] o_la,
  output logic [16:0] o_sa,
  output logic [7:0] o_sd,
  output logic o_master,
  output logic o_dma,
  output logic o_refresh,
  output logic o_mem,
  output logic o_io,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    {o_la, o_sa, o_sd} = '0;
    {o_master, o_dma, o_refresh, o_mem, o_io, o_wr, o_rd} = '0;
  end
  // Kind 0 memory, 1 I/O read, 2 I/O write
  task automatic start(input logic [31:0] a, input logic [7:0] d,
      input logic [1:0] k, input logic m, input logic dm,
      input logic rf);
    @(posedge i_clk);
    {o_la, o_sa} <= a;
    o_sd <= d;
    o_master <= m;
    o_dma <= dm;
    o_refresh <= rf;
    o_mem <= k == 2'h0;
    o_io <= k != 2'h0;
    o_rd <= k == 2'h1;
    o_wr <= k == 2'h2;
  endtask
  // Released lines flip so a stale address is never mistaken for live
  task automatic stop();
    @(posedge i_clk);
    {o_la, o_sa, o_sd} <= ~{o_la, o_sa, o_sd};
    {o_master, o_dma, o_refresh, o_mem, o_io, o_wr, o_rd} <= '0;
  endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic [3:0] ra = 4'h0;
  logic [7:0] wd = 8'h00;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic hit = 1'h0;
  logic [7:0] rdat;
  logic [31:17] la;
  logic [16:0] sa;
  logic [7:0] sd;
  logic m, dm, rf, mc, ic, iw, ir;
  logic fwd, cont, fsel_n, claim, io8, rdy, mouse;
  iad_pkg::iad_cs_t cs;
  logic [7:0] cfg [10];
  int n_errors = 0;
  int num_checks = 0;
  int n_mouse = 0;
  logic [31:0] mtab [11] = '{32'h0007_FFFF, 32'h0008_0000, 32'h0009_FFFF,
    32'h000B_FFFF, 32'h000C_0000, 32'h000D_FFFF, 32'h000E_0000,
    32'h000F_FFFF, 32'h0010_0000, 32'h00FF_FFFF, 32'h0100_0000};
  logic [15:0] itab [24] = '{16'h0060, 16'h0062, 16'h0064, 16'h0066,
    16'h0070, 16'h0071, 16'h0076, 16'h0077, 16'h0170, 16'h0177,
    16'h0178, 16'h01F0, 16'h01F7, 16'h016F, 16'h0278, 16'h027B,
    16'h027F, 16'h0277, 16'h02F8, 16'h02FF, 16'h02F7, 16'h0372,
    16'h03F2, 16'h1060};
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) if (mouse === 1'h1) n_mouse++;
  iad_isa_agent agent_u (.i_clk(i_clk), .o_la(la), .o_sa(sa), .o_sd(sd),
    .o_master(m), .o_dma(dm), .o_refresh(rf), .o_mem(mc), .o_io(ic),
    .o_wr(iw), .o_rd(ir));
  iad_decoder dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(ra),
    .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat),
    .i_la(la), .i_sa(sa), .i_sd(sd), .i_isa_master(m), .i_dma(dm),
    .i_refresh(rf), .i_mem_cycle(mc), .i_io_cycle(ic), .i_io_wr(iw),
    .i_io_rd(ir), .i_int_reg_hit(hit), .o_fwd_pci(fwd),
    .o_contain_isa(cont), .o_encoded_firmware_select_n(fsel_n),
    .o_bios_claim(claim), .o_cs_code(cs), .o_io8_ext(io8),
    .o_iochrdy_drive(rdy), .o_mouse_read(mouse));
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    wr <= 1'h1;
    ra <= a;
    wd <= d;
    @(posedge i_clk);
    wr <= 1'h0;
    if (a < 4'h6) cfg[a] = d;
    @(posedge i_clk);
  endtask
  task automatic rreg(input logic [3:0] a);
    rd <= 1'h1;
    ra <= a;
    @(posedge i_clk);
    rd <= 1'h0;
    #1;
    chk("reg", rdat, cfg[a]);
    @(posedge i_clk);
  endtask
  function automatic logic [2:0] exp_mem(logic [31:0] a, logic dm, mr, r);
    logic [15:0] p;
    logic lo, hi, f;
    p = a[31:16];
    lo = p == 16'h000E || dm && (p == 16'hFFFE || p == 16'hFFEE);
    hi = p == 16'h000F || dm && (p == 16'hFFFF || p == 16'hFFEF);
    if (a < 32'h0008_0000) f = cfg[0][0];
    else if (a < 32'h000A_0000) f = cfg[0][1];
    else if (a < 32'h000C_0000) f = cfg[0][2];
    else if (a < 32'h000E_0000) f = cfg[1][a[16:14]];
    else if (lo) f = !cfg[4][6] && (cfg[0][3] || cfg[0][6]);
    else if (hi) f = 1'h0;
    else if (a[31:24] != 8'h00) f = 1'h1;
    else f = a[23:20] <= cfg[0][7:4] &&
      !(a[23:16] >= cfg[3] && a[23:16] <= cfg[2]);
    return {f & !r, !dm && !r && mr &&
      (p == 16'h000F || p == 16'h000E && cfg[4][6]),
      !dm && !r && mr && cfg[5][6] && p == 16'h000F};
  endfunction
  function automatic iad_pkg::iad_cs_t exp_cs(logic [15:0] a, logic w);
    logic [12:0] h;
    h = a[15:3];
    if (cfg[4][0] && h == 13'h000C && !a[0]) return iad_pkg::IAD_CS_KEYBOARD;
    if (cfg[4][1] && h == 13'h000E && a[0]) return iad_pkg::IAD_CS_CLK_SEL;
    if (cfg[4][1] && h == 13'h000E && w) return iad_pkg::IAD_CS_CLK_ADDR;
    if (cfg[4][2] && (h == 13'h002E || h == 13'h003E))
      return iad_pkg::IAD_CS_DISK0;
    if (cfg[4][3] && h == 13'h004F) return iad_pkg::IAD_CS_PARALLEL;
    if (cfg[4][4] && h == 13'h005F) return iad_pkg::IAD_CS_SERIAL2;
    return iad_pkg::IAD_CS_NONE;
  endfunction
  function automatic logic [31:0] rnd_addr(logic d);
    logic [31:0] a;
    logic [1:0] k;
    a = $urandom;
    k = 2'($urandom);
    if (k == 2'h0) a[31:20] = 12'h000;
    else if (k == 2'h1 || !d) a[31:24] = 8'h00;
    else if (k == 2'h2) a[31:16] = {11'h7FF, a[20], 3'h7, a[16]};
    return a;
  endfunction
  task automatic mem_chk(input logic [31:0] a, input logic d, r);
    logic [2:0] e;
    e = exp_mem(a, d, !d, r);
    agent_u.start(a, 8'h00, 2'h0, !d, d, r);
    #1;
    chk("fwd", fwd, e[2]);
    chk("contain", cont, !e[2]);
    chk("fsel_n", fsel_n, !e[1]);
    chk("claim", claim, e[0]);
  endtask
  task automatic io_chk(input logic [15:0] a);
    logic w, mr;
    logic [7:0] d;
    int n0;
    w = 1'($urandom);
    mr = 1'($urandom);
    d = 8'($urandom);
    n0 = n_mouse;
    agent_u.start({16'h0000, a}, d, w ? 2'h2 : 2'h1, mr, 1'h0, 1'h0);
    hit <= 1'($urandom);
    #1;
    chk("cs", cs, exp_cs(a, w));
    chk("rdy", rdy, w & mr & (a == 16'h0070 | a == 16'h0372 |
      a == 16'h03F2));
    chk("io8", io8, mr & hit);
    chk("io_contain", cont, 1'h1);
    // Strobe held long enough for the capture synchroniser
    repeat (4) @(posedge i_clk);
    agent_u.stop();
    repeat (3) @(posedge i_clk);
    chk("mouse", n_mouse - n0, !w && a == 16'h0060);
    if (w && mr && a == 16'h0070) cfg[6] = d;
    if (w && mr && a == 16'h0372) cfg[7] = d;
    if (w && mr && a == 16'h03F2) cfg[8] = d;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    logic d;
    foreach (cfg[i]) cfg[i] = 8'h00;
    void'($urandom(32'h7e30_e836));
    repeat (8) @(posedge i_clk);
    i_rst <= 1'h0;
    @(posedge i_clk);
    for (int i = 0; i < 10; i++) rreg(4'(i));
    repeat (6) begin
      for (int i = 0; i < 6; i++) wreg(4'(i), 8'($urandom));
      wreg(4'h9, 8'h5A);
      wreg(4'h6, 8'hA5);
      for (int i = 0; i < 10; i++) rreg(4'(i));
      foreach (mtab[i]) mem_chk(mtab[i], 1'h0, 1'h0);
      repeat (60) begin
        d = 1'($urandom);
        mem_chk(rnd_addr(d), d, $urandom % 8 == 0);
      end
      foreach (itab[i]) io_chk(itab[i]);
      repeat (20) io_chk(16'($urandom % 1024));
      for (int i = 6; i < 9; i++) rreg(4'(i));
    end
    // Mid-run reset must clear every register and shadow
    i_rst <= 1'h1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'h0;
    foreach (cfg[i]) cfg[i] = 8'h00;
    @(posedge i_clk);
    for (int i = 0; i < 10; i++) rreg(4'(i));
    mem_chk(32'h000F_0000, 1'h0, 1'h0);
    wrap_up();
  end
endmodule
